// *** core/eag_top.sv ***
// effective address generator datapath, one registered stage
`timescale 1ns/100ps
`default_nettype none
module eag_top import eag_pkg::*; (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  // decoded request
  input  wire logic              req_valid,
  input  var  eag_mode_type      req_mode,
  input  var  eag_size_type      req_size,
  input  wire logic [EAG_DISP_W-1:0] req_disp,
  input  wire logic [3:0]        req_reg_num,
  // register file and program counter
  input  wire logic [EAG_AW-1:0] base_register,
  input  wire logic [EAG_AW-1:0] pc_current,
  // mmu control register fields
  input  wire logic              translation_enable_bit,
  input  wire logic              single_virtual_space_bit,
  input  wire logic [EAG_ADDRESS_SPACE_IDENTIFIER_W-1:0] address_space_identifier,
  // memory access path
  output logic                   ea_valid_r,
  output logic [EAG_AW-1:0]      ea_r,
  output logic                   xlat_req_r,
  output logic                   address_space_identifier_valid_r,
  output logic [EAG_ADDRESS_SPACE_IDENTIFIER_W-1:0]  address_space_identifier_r,
  // branch unit
  output logic                   br_valid_r,
  output logic [EAG_AW-1:0]      br_target_r,
  // register direct operand and base write-back
  output logic                   opnd_valid_r,
  output logic [EAG_AW-1:0]      opnd_r,
  output logic                   wb_valid_r,
  output logic [3:0]             wb_reg_num_r,
  output logic [EAG_AW-1:0]      wb_data_r
);
  // ---------------------------------------------------------------
  // address arithmetic
  // ---------------------------------------------------------------
  logic [EAG_AW-1:0] step;
  logic [EAG_AW-1:0] disp_zx_scaled;
  logic [EAG_AW-1:0] disp_sx_x2;
  logic [EAG_AW-1:0] pc_base;
  logic [EAG_AW-1:0] ld_addr;
  logic [EAG_AW-1:0] br_addr;
  logic [EAG_AW-1:0] dec_addr;
  logic [EAG_AW-1:0] inc_addr;
  logic              is_mem;

  // one step feeds both adders; the unused sum is simply dropped
  assign step    = eag_step(req_size);
  assign dec_addr = base_register - step;
  assign inc_addr = base_register + step;
  // long scales by 4 with masked pc; anything else scales by 2
  assign disp_zx_scaled = (req_size == EAG_LONG) ? {22'h0, req_disp, 2'h0}
                                                 : {23'h0, req_disp, 1'h0};
  assign pc_base = (req_size == EAG_LONG) ? (pc_current & EAG_LONG_MASK)
                                          : pc_current;
  assign ld_addr = pc_base + EAG_PC_OFFSET + disp_zx_scaled;
  // branch ignores size: a branch is always halfword scaled
  assign disp_sx_x2 = {{23{req_disp[EAG_DISP_W-1]}}, req_disp, 1'h0};
  assign br_addr = pc_current + EAG_PC_OFFSET + disp_sx_x2;
  // only these modes touch memory, so only they may ask for translation
  assign is_mem = req_valid && (req_mode inside {EAG_INDIRECT, EAG_POSTINC,
                                                 EAG_PREDEC, EAG_PCREL_LD});

  // ---------------------------------------------------------------
  // effective address stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ea_valid_r <= 1'b0;
      ea_r       <= EAG_RST_WORD;
    end else if (ce) begin
      ea_valid_r <= is_mem;
      unique case (req_mode)
        EAG_PREDEC:   ea_r <= dec_addr;
        EAG_PCREL_LD: ea_r <= ld_addr;
        default:      ea_r <= base_register;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // translation hand-off
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      xlat_req_r   <= 1'b0;
      address_space_identifier_valid_r <= 1'b0;
      address_space_identifier_r       <= EAG_RST_ADDRESS_SPACE_IDENTIFIER;
    end else if (ce) begin
      xlat_req_r   <= is_mem && translation_enable_bit;
      address_space_identifier_valid_r <= is_mem && translation_enable_bit && !single_virtual_space_bit;
      // zero in single space, so a stale id never reaches translation
      address_space_identifier_r       <= single_virtual_space_bit ? EAG_RST_ADDRESS_SPACE_IDENTIFIER : address_space_identifier;
    end
  end

  // ---------------------------------------------------------------
  // branch target and register direct operand
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      br_valid_r   <= 1'b0;
      br_target_r  <= EAG_RST_WORD;
      opnd_valid_r <= 1'b0;
      opnd_r       <= EAG_RST_WORD;
    end else if (ce) begin
      br_valid_r   <= req_valid && (req_mode == EAG_PCREL_BR);
      br_target_r  <= br_addr;
      // direct mode never raises ea_valid_r
      opnd_valid_r <= req_valid && (req_mode == EAG_DIRECT);
      opnd_r       <= base_register;
    end
  end

  // ---------------------------------------------------------------
  // base register write-back
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wb_valid_r   <= 1'b0;
      wb_reg_num_r <= EAG_RST_REG;
      wb_data_r    <= EAG_RST_WORD;
    end else if (ce) begin
      // indirect mode leaves the base alone
      wb_valid_r   <= req_valid && (req_mode inside {EAG_POSTINC, EAG_PREDEC});
      wb_reg_num_r <= req_reg_num;
      // data is don't-care outside stepping modes, so no extra mux
      wb_data_r    <= (req_mode == EAG_PREDEC) ? dec_addr : inc_addr;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // each check looks one edge after the request edge; frozen edges hold

  chk_indirect_addr: assert property (ce && req_valid && req_mode == EAG_INDIRECT |=>
    ea_valid_r && ea_r == $past(base_register) && !wb_valid_r)
    else $error("indirect address wrong");
  chk_postinc_step: assert property (ce && req_valid && req_mode == EAG_POSTINC |=>
    ea_r == $past(base_register) && wb_data_r == ea_r + eag_step($past(req_size)))
    else $error("post-increment wrong");
  chk_predec_addr: assert property (ce && req_valid && req_mode == EAG_PREDEC |=>
    wb_valid_r && wb_data_r == ea_r && ea_r == $past(base_register) - eag_step($past(req_size)))
    else $error("pre-decrement wrong");
  chk_direct_noaddr: assert property (ce && req_valid && req_mode == EAG_DIRECT |=>
    !ea_valid_r && opnd_valid_r && !xlat_req_r)
    else $error("direct mode made an address");
  chk_pcrel_word: assert property (ce && req_valid && req_mode == EAG_PCREL_LD
    && req_size == EAG_WORD |=> ea_r == $past(pc_current) + EAG_PC_OFFSET
    + {23'h0, $past(req_disp), 1'h0})
    else $error("pc-relative word wrong");
  chk_pcrel_long: assert property (ce && req_valid && req_mode == EAG_PCREL_LD
    && req_size == EAG_LONG |=> ea_r == ($past(pc_current) & EAG_LONG_MASK) + EAG_PC_OFFSET
    + {22'h0, $past(req_disp), 2'h0})
    else $error("pc-relative long wrong");
  chk_branch_target: assert property (ce && req_valid && req_mode == EAG_PCREL_BR |=>
    br_valid_r && br_target_r == $past(pc_current) + EAG_PC_OFFSET
    + {{23{$past(req_disp[EAG_DISP_W-1])}}, $past(req_disp), 1'h0})
    else $error("branch target wrong");
  chk_xlat_enable: assert property (ce |=> xlat_req_r == ($past(is_mem)
    && $past(translation_enable_bit)))
    else $error("translation request wrong");
  chk_address_space_identifier_supply: assert property (ce && is_mem && translation_enable_bit
    && !single_virtual_space_bit |=> address_space_identifier_valid_r && address_space_identifier_r == $past(address_space_identifier))
    else $error("space identifier wrong");
  chk_freeze: assert property (!ce |=> $stable(ea_r) && $stable(wb_data_r))
    else $error("state moved with enable low");
  // a low enable must hold the ea, write-back and operand valids and the branch target
  chk_freeze_flags: assert property (!ce |=> $stable(ea_valid_r) && $stable(wb_valid_r)
    && $stable(br_target_r) && $stable(opnd_valid_r))
    else $error("flags moved with enable low");
  chk_freeze_xlat: assert property (!ce |=> $stable(xlat_req_r) && $stable(address_space_identifier_r)
    && $stable(opnd_r))
    else $error("translation outputs moved with enable low");

  chk_direct_operand: assert property (ce && req_valid && req_mode == EAG_DIRECT |=>
    opnd_r == $past(base_register) && !wb_valid_r && !br_valid_r)
    else $error("direct operand wrong");
  chk_operand_only: assert property (ce && req_valid && req_mode != EAG_DIRECT |=>
    !opnd_valid_r)
    else $error("operand valid outside direct mode");
  chk_postinc_valid: assert property (ce && req_valid && req_mode == EAG_POSTINC |=>
    ea_valid_r && wb_valid_r && wb_reg_num_r == $past(req_reg_num))
    else $error("post-increment write-back missing");
  chk_predec_regnum: assert property (ce && req_valid && req_mode == EAG_PREDEC |=>
    ea_valid_r && wb_reg_num_r == $past(req_reg_num))
    else $error("pre-decrement register number wrong");
  chk_pcrel_noback: assert property (ce && req_valid && req_mode == EAG_PCREL_LD |=>
    ea_valid_r && !wb_valid_r)
    else $error("pc-relative load wrote a base");
  chk_branch_noaddr: assert property (ce && req_valid && req_mode == EAG_PCREL_BR |=>
    !ea_valid_r && !wb_valid_r && !xlat_req_r)
    else $error("branch made a memory access");
  chk_xlat_off: assert property (ce && !translation_enable_bit |=>
    !xlat_req_r && !address_space_identifier_valid_r)
    else $error("translation requested while disabled");
  chk_single_space: assert property (ce && single_virtual_space_bit |=>
    !address_space_identifier_valid_r && address_space_identifier_r == EAG_RST_ADDRESS_SPACE_IDENTIFIER)
    else $error("space identifier in single space");
  chk_idle_quiet: assert property (ce && !req_valid |=> !ea_valid_r && !br_valid_r
    && !opnd_valid_r && !wb_valid_r)
    else $error("valid without a request");

  // ---------------------------------------------------------------
  // coverage
  // ---------------------------------------------------------------
  cov_postinc: cover property (ce && req_valid && req_mode == EAG_POSTINC ##1 wb_valid_r);
  cov_branch:  cover property (br_valid_r);
  cov_xlat:    cover property (xlat_req_r && address_space_identifier_valid_r);
  cov_pcrel_long: cover property (ce && req_valid && req_mode == EAG_PCREL_LD
    && req_size == EAG_LONG);
  cov_freeze:  cover property (!ce && req_valid);
endmodule // eag_top
`default_nettype wire

// *** core/eag_pkg.sv ***
// package: constants and types for the effective address generator
package eag_pkg;
  // ---------------------------------------------------------------
  // constants
  // ---------------------------------------------------------------
  localparam int          EAG_AW        = 32;
  localparam int          EAG_DISP_W    = 8;
  localparam int          EAG_ADDRESS_SPACE_IDENTIFIER_W    = 8;
  localparam logic [31:0] EAG_PC_OFFSET = 32'h0000_0004;
  localparam logic [31:0] EAG_LONG_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] EAG_RST_WORD  = 32'h0000_0000;
  localparam logic [7:0]  EAG_RST_ADDRESS_SPACE_IDENTIFIER  = 8'h00;
  localparam logic [3:0]  EAG_RST_REG   = 4'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    EAG_DIRECT, EAG_INDIRECT, EAG_POSTINC, EAG_PREDEC, EAG_PCREL_LD, EAG_PCREL_BR
  } eag_mode_type;

  typedef enum logic [1:0] {EAG_BYTE, EAG_WORD, EAG_LONG, EAG_QUAD} eag_size_type;

  // operand size in bytes for base register stepping
  function automatic logic [31:0] eag_step(input eag_size_type sz);
    unique case (sz)
      EAG_BYTE: eag_step = 32'h0000_0001;
      EAG_WORD: eag_step = 32'h0000_0002;
      EAG_LONG: eag_step = 32'h0000_0004;
      EAG_QUAD: eag_step = 32'h0000_0008;
    endcase
  endfunction
endpackage

// *** dv/eag_rf_model.sv ***
// register file model that feeds the address generator
`timescale 1ns/100ps
`default_nettype none
module eag_rf_model import eag_pkg::*; (
  // clock
  input  wire logic              clk,
  // read port
  input  wire logic [3:0]        rd_num,
  output logic [EAG_AW-1:0]      rd_data,
  // base write-back port
  input  wire logic              wr_en,
  input  wire logic [3:0]        wr_num,
  input  wire logic [EAG_AW-1:0] wr_data
);
  logic [EAG_AW-1:0] regs_r [16];
  initial for (int i = 0; i < 16; i++) regs_r[i] = (i << 12) + 32'h0000_0040;
  assign rd_data = regs_r[rd_num];
  // write lands one edge after the pulse, so the next request sees it
  always @(posedge clk) if (wr_en) regs_r[wr_num] <= wr_data;
endmodule // eag_rf_model
`default_nettype wire

// *** dv/effective_address_generator_tb.sv ***
// testbench for the address generator with a register file model
`timescale 1ns/100ps
`default_nettype none
module effective_address_generator_tb import eag_pkg::*;;
  logic         clk = 1'b0, rstn = 1'b0, ce = 1'b1, req_valid = 1'b0;
  logic         translation_enable_bit = 1'b0, single_virtual_space_bit = 1'b1;
  eag_mode_type req_mode = EAG_DIRECT;
  eag_size_type req_size = EAG_BYTE;
  logic [7:0]   req_disp = 8'h00, address_space_identifier = 8'h5A, address_space_identifier_r;
  logic [3:0]   req_reg_num = 4'h0, wb_reg_num_r;
  logic [31:0]  pc_current = 32'h0000_1002, base_register, ea_r, br_target_r;
  logic [31:0]  opnd_r, wb_data_r, b;
  logic         ea_valid_r, xlat_req_r, address_space_identifier_valid_r, br_valid_r, opnd_valid_r, wb_valid_r;
  int           errors = 0, comparisons = 0;
  always #12.5 clk = ~clk;
  eag_top dut_u (.clk, .rstn, .ce, .req_valid, .req_mode, .req_size, .req_disp, .req_reg_num,
    .base_register, .pc_current, .translation_enable_bit, .single_virtual_space_bit,
    .address_space_identifier, .ea_valid_r, .ea_r, .xlat_req_r, .address_space_identifier_valid_r, .address_space_identifier_r,
    .br_valid_r, .br_target_r, .opnd_valid_r, .opnd_r, .wb_valid_r, .wb_reg_num_r, .wb_data_r);
  eag_rf_model rf_u (.clk, .rd_num(req_reg_num), .rd_data(base_register),
    .wr_en(wb_valid_r), .wr_num(wb_reg_num_r), .wr_data(wb_data_r));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one request, answer sampled after the edge that takes it
  task automatic send(input eag_mode_type m, input eag_size_type s, input logic [7:0] d,
                      input logic [3:0] n);
    @(posedge clk);
    req_valid   <= 1'b1;
    req_mode    <= m;
    req_size    <= s;
    req_disp    <= d;
    req_reg_num <= n;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_plain();
    b = rf_u.regs_r[3];
    send(EAG_DIRECT, EAG_LONG, 8'h00, 4'h3);
    chk({31'h0, opnd_valid_r}, 32'h1, "operand valid");
    chk(opnd_r, b, "operand");
    chk({31'h0, ea_valid_r}, 32'h0, "direct gave address");
    send(EAG_INDIRECT, EAG_WORD, 8'h00, 4'h3);
    chk(ea_r, b, "indirect address");
    chk({31'h0, ea_valid_r}, 32'h1, "indirect valid");
    chk({31'h0, wb_valid_r}, 32'h0, "indirect wrote base");
    $display("test plain done");
  endtask
  task automatic t_steps();
    // every pair hands the base back unchanged, so one snapshot serves all sizes
    b = rf_u.regs_r[5];
    for (int s = 0; s < 4; s++) begin
      send(EAG_POSTINC, eag_size_type'(s), 8'h00, 4'h5);
      chk(ea_r, b, "postinc address");
      chk(wb_data_r, b + (32'h1 << s), "postinc base");
      chk({28'h0, wb_reg_num_r}, 32'h5, "postinc reg");
      chk({31'h0, wb_valid_r}, 32'h1, "postinc write");
      send(EAG_PREDEC, eag_size_type'(s), 8'h00, 4'h5);
      chk(ea_r, b, "predec address");
      chk(wb_data_r, b, "predec base");
      chk({31'h0, wb_valid_r}, 32'h1, "predec write");
    end
    $display("test steps done");
  endtask
  task automatic t_pcrel();
    send(EAG_PCREL_LD, EAG_WORD, 8'hFF, 4'h0);
    chk(ea_r, 32'h0000_1204, "word pc load");
    send(EAG_PCREL_LD, EAG_LONG, 8'hFF, 4'h0);
    chk(ea_r, 32'h0000_1400, "long pc load");
    send(EAG_PCREL_BR, EAG_WORD, 8'h80, 4'h0);
    chk(br_target_r, 32'h0000_0F06, "backward branch");
    chk({31'h0, br_valid_r}, 32'h1, "branch valid");
    send(EAG_PCREL_BR, EAG_WORD, 8'h7F, 4'h0);
    chk(br_target_r, 32'h0000_1104, "forward branch");
    $display("test pc relative done");
  endtask
  task automatic t_xlat();
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      translation_enable_bit   <= k[0];
      single_virtual_space_bit <= k[1];
      send(EAG_INDIRECT, EAG_LONG, 8'h00, 4'h1);
      chk({31'h0, xlat_req_r}, {31'h0, k[0]}, "translate request");
      chk({31'h0, address_space_identifier_valid_r}, {31'h0, k[0] & ~k[1]}, "space id valid");
      if (k[0]) chk({24'h0, address_space_identifier_r}, k[1] ? 32'h0 : 32'h5A, "space id");
    end
    $display("test translation done");
  endtask
  task automatic t_freeze();
    b = rf_u.regs_r[2];
    @(posedge clk);
    ce          <= 1'b0;
    req_valid   <= 1'b1;
    req_mode    <= EAG_POSTINC;
    req_size    <= EAG_LONG;
    req_reg_num <= 4'h2;
    // two frozen edges: the standing request must not be taken
    repeat (2) @(posedge clk);
    #1;
    chk({31'h0, ea_valid_r}, 32'h0, "frozen address valid");
    chk({31'h0, wb_valid_r}, 32'h0, "frozen write-back");
    chk(ea_r, rf_u.regs_r[1], "frozen address");
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    req_valid <= 1'b0;
    #1;
    chk({31'h0, ea_valid_r}, 32'h1, "thawed address valid");
    chk(ea_r, b, "thawed address");
    chk(wb_data_r, b + 32'h4, "thawed base");
    $display("test freeze done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_plain();
    t_steps();
    t_pcrel();
    t_xlat();
    t_freeze();
    wrap_up();
  end
  // hang guard, far beyond the length of the run
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("BAD t=%0t run did not finish", $time);
    wrap_up();
  end
endmodule // effective_address_generator_tb
`default_nettype wire
